// >>> hw/pps_pkg.sv
// shared constants and types for the poe port sequencer and its host
package pps_pkg;
   localparam int CLK_HZ = 125_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int NPORT = 4;
   localparam int TW = 28;
   localparam int START_MS = 65;
   localparam int START_CYC = START_MS * CYC_PER_MS;
   localparam int DISC_MS = 322;
   localparam int DISC_CYC = DISC_MS * CYC_PER_MS;
   localparam int RECOV_MS = 1000;
   localparam int RECOV_CYC = RECOV_MS * CYC_PER_MS;
   localparam int OVL_MS = 50;
   localparam int OVL_CYC = OVL_MS * CYC_PER_MS;
   localparam int SHORT_MS = 60;
   localparam int SHORT_CYC = SHORT_MS * CYC_PER_MS;
   localparam int DET_STEP_US = 20;
   localparam int DET_STEP_CYC = DET_STEP_US * CYC_PER_US;
   localparam int CLS_EV_US = 10;
   localparam int CLS_EV_CYC = CLS_EV_US * CYC_PER_US;
   localparam int CS_SETUP_NS = 340;
   localparam int CS_SETUP_CYC = (CS_SETUP_NS * CYC_PER_US + 999) / 1000;
   localparam int CS_HOLD_NS = 340;
   localparam int CS_HOLD_CYC = (CS_HOLD_NS * CYC_PER_US + 999) / 1000;
   localparam int SCK_HALF_CYC = 8;
   localparam int BYTE_GAP_SCK = 1;
   localparam int FRAME_GAP_SCK = 2;
   localparam logic [7:0] DEV_ADDR_RST = 8'h20;
   localparam int RD_BIT = 7;
   localparam logic [6:0] REG_STAT = 7'h00;
   localparam logic [6:0] REG_CTRL = 7'h10;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam int CTRL_EN_LSB = 0;
   localparam int CTRL_T2_LSB = 4;
   localparam int CTRL_LEG_LSB = 8;
   localparam int ST_PWR = 0;
   localparam int ST_CLS_LSB = 1;
   localparam int ST_FLT_LSB = 4;
   localparam int ST_STATE_LSB = 8;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01, S_DET = 6'h02, S_CLS = 6'h04,
      S_START = 6'h08, S_ON = 6'h10, S_WAIT = 6'h20
   } pps_port_st_t;
   typedef enum logic [2:0] {
      FLT_NONE = 3'h0, FLT_SHORT = 3'h1, FLT_OVL = 3'h2,
      FLT_NOLOAD = 3'h3, FLT_TEMP = 3'h4, FLT_VMAIN = 3'h5
   } pps_fault_t;
   typedef enum logic [5:0] {
      H_IDLE = 6'h01, H_SETUP = 6'h02, H_BIT = 6'h04,
      H_GAP = 6'h08, H_HOLD = 6'h10, H_CSHI = 6'h20
   } pps_host_st_t;
endpackage

// >>> hw/pps_spi_if.sv
// serial link between the host and the port sequencer
interface pps_spi_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   modport host (output sck, output cs_n, output mosi, input miso, input miso_oe);
   modport dev (input sck, input cs_n, input mosi, output miso, output miso_oe);
endinterface

// >>> hw/pps_port_fsm.sv
// one port: detection, classification, start-up and protection
module pps_port_fsm
#(
   parameter int START_C = 1,
   parameter int DISC_C = 1,
   parameter int RECOV_C = 1,
   parameter int OVL_C = 1,
   parameter int SHORT_C = 1
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic en,
   input wire logic type2,
   input wire logic legacy,
   input wire logic sig_ok,
   input wire logic cap_ok,
   input wire logic at_lim,
   input wire logic over_cut,
   input wire logic under_min,
   input wire logic [2:0] cls_code,
   input wire logic ovt,
   input wire logic vhi,
   output logic det_on,
   output logic [1:0] det_lvl,
   output logic cls_on,
   output logic pwr_on,
   output logic inrush,
   output logic [15:0] status
);
   import pps_pkg::*;
   pps_port_st_t st_q, st_d;
   pps_fault_t flt_q, flt_d;
   logic [TW-1:0] tmr_q, tmr_d, lim_q, lim_d, cut_q, cut_d, min_q, min_d;
   logic [1:0] step_q, step_d, lvl_d;
   logic [2:0] cls_q, cls_d;
   logic det_d, cev_d, pwr_d, inr_d, live;

   always_comb
   begin
      st_d = st_q;
      flt_d = flt_q;
      step_d = step_q;
      cls_d = cls_q;
      tmr_d = tmr_q + TW'(1);
      live = (st_q == S_START) || (st_q == S_ON);
      lim_d = (live && at_lim) ? lim_q + TW'(1) : '0;
      cut_d = (st_q == S_ON && over_cut) ? cut_q + TW'(1) : '0;
      min_d = (st_q == S_ON && under_min) ? min_q + TW'(1) : '0;
      case (st_q)
         S_IDLE:
         begin
            step_d = '0;
            if (en && !ovt && !vhi)
               st_d = S_DET;
         end
         S_DET:
            if (tmr_q == TW'(DET_STEP_CYC - 1))
            begin
               tmr_d = '0;
               step_d = step_q + 2'd1;
               if (step_q == 2'd3)
                  st_d = (sig_ok || (legacy && cap_ok)) ? S_CLS : S_WAIT;
            end
         S_CLS:
            if (tmr_q == TW'(CLS_EV_CYC - 1))
            begin
               tmr_d = '0;
               step_d = step_q + 2'd1;
               if (step_q == 2'd2 || (step_q == 2'd0 && !type2))
               begin
                  cls_d = cls_code;
                  flt_d = FLT_NONE;
                  step_d = '0;
                  st_d = S_START;
               end
            end
         S_START:
            if (tmr_q == TW'(START_C - 1))
               st_d = S_ON;
         S_ON:
            tmr_d = '0;
         S_WAIT:
            if (tmr_q == TW'(RECOV_C - 1))
               st_d = S_IDLE;
         default:
            st_d = S_IDLE;
      endcase
      // short, temperature and supply protection are armed whenever the port carries power; overload and no-load only in S_ON
      if (live)
      begin
         if (lim_q == TW'(SHORT_C))
         begin
            st_d = S_IDLE;
            flt_d = FLT_SHORT;
         end
         else if (cut_q == TW'(OVL_C))
         begin
            st_d = S_WAIT;
            flt_d = FLT_OVL;
         end
         else if (min_q == TW'(DISC_C))
         begin
            st_d = S_WAIT;
            flt_d = FLT_NOLOAD;
         end
         if (ovt)
         begin
            st_d = S_IDLE;
            flt_d = FLT_TEMP;
         end
         if (vhi)
         begin
            st_d = S_IDLE;
            flt_d = FLT_VMAIN;
         end
      end
      // a global fault also halts a port still detecting or classifying
      if ((ovt || vhi) && !live && st_q != S_WAIT)
         st_d = S_IDLE;
      if (!en)
         st_d = S_IDLE;
      if (st_d != st_q)
         tmr_d = '0;
      det_d = (st_d == S_DET);
      lvl_d = (st_d == S_DET) ? step_d : 2'd0;
      cev_d = (st_d == S_CLS) && (step_d != 2'd1);
      pwr_d = (st_d == S_START) || (st_d == S_ON);
      inr_d = (st_d == S_START);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= S_IDLE;
         flt_q <= FLT_NONE;
         step_q <= '0;
         cls_q <= '0;
         tmr_q <= '0;
         lim_q <= '0;
         cut_q <= '0;
         min_q <= '0;
         det_on <= 1'b0;
         det_lvl <= '0;
         cls_on <= 1'b0;
         pwr_on <= 1'b0;
         inrush <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         flt_q <= flt_d;
         step_q <= step_d;
         cls_q <= cls_d;
         tmr_q <= tmr_d;
         lim_q <= lim_d;
         cut_q <= cut_d;
         min_q <= min_d;
         det_on <= det_d;
         det_lvl <= lvl_d;
         cls_on <= cev_d;
         pwr_on <= pwr_d;
         inrush <= inr_d;
      end
   end

   assign status = {2'b00, st_q, 1'b0, flt_q, cls_q, pwr_on};
endmodule

// >>> hw/pps_device.sv
// four-port poe sequencer with its serial slave
// Overview of operation
// - classify only after successful signature detection
// - one class event type1, two type2
// - four detect levels, accept 19K-26.5K
// - legacy setting also accepts capacitive loads
// - start-up holds 425 mA for 65 ms
// - powered port arms short protection, on state adds overload/no-load, cuts faults
// - under 7.5 mA past 322 ms disconnects
// - junction over 200 C removes power
// - supply above 60 V removes power
// - frame is device, register, msb, lsb
// - master pauses one clock between bytes
// - two clocks between frames
// - chip select high one clock between frames
// - read data valid 15.5-23.75 clocks
// - held at limit past timer is short
// - over cutoff past timer is overload
// - retry after overload/no-load once per second
// - sequencing runs from the system oscillator
module pps_device
#(
   parameter logic [7:0] DEV_ADDR = pps_pkg::DEV_ADDR_RST,
   parameter int START_C = pps_pkg::START_CYC,
   parameter int DISC_C = pps_pkg::DISC_CYC,
   parameter int RECOV_C = pps_pkg::RECOV_CYC,
   parameter int OVL_C = pps_pkg::OVL_CYC,
   parameter int SHORT_C = pps_pkg::SHORT_CYC
)
(
   input wire logic CLK_SYS,
   input wire logic NRST,
   pps_spi_if.dev SPI,
   input wire logic [pps_pkg::NPORT-1:0] SIG_OK,
   input wire logic [pps_pkg::NPORT-1:0] CAP_OK,
   input wire logic [pps_pkg::NPORT-1:0] AT_LIM,
   input wire logic [pps_pkg::NPORT-1:0] OVER_CUT,
   input wire logic [pps_pkg::NPORT-1:0] UNDER_MIN,
   input wire logic [3*pps_pkg::NPORT-1:0] CLS_CODE,
   input wire logic OVER_TEMP,
   input wire logic VMAIN_HIGH,
   output logic [pps_pkg::NPORT-1:0] DET_ON,
   output logic [2*pps_pkg::NPORT-1:0] DET_LEVEL,
   output logic [pps_pkg::NPORT-1:0] CLASS_ON,
   output logic [pps_pkg::NPORT-1:0] PORT_PWR,
   output logic [pps_pkg::NPORT-1:0] INRUSH_LIM
);
   import pps_pkg::*;
   localparam int SW = 36;

   // link side, clocked by the serial clock
   logic link_rst;
   logic [31:0] sh_q, sh_d;
   logic [4:0] bcnt_q, bcnt_d;
   logic rd_q, rd_d;
   logic [15:0] rsh_q, rsh_d, rd_word;
   logic wtgl_q, wtgl_d;
   logic [6:0] wreg_q, wreg_d;
   logic [15:0] wdat_q, wdat_d;
   logic miso_q, oe_q;

   // system side
   logic [SW-1:0] pin_raw, s1_q, s2_q, s3_q, pin_q, pin_d;
   logic wseen_q, wevt;
   logic [15:0] ctrl_q, ctrl_d, sctrl_q, sctrl_d;
   logic [15:0] stat [NPORT];
   logic [15:0] snap_q [NPORT];
   logic [15:0] snap_d [NPORT];

   // frame state restarts with every chip select
   assign link_rst = SPI.cs_n | ~NRST;

   always_comb
   begin
      rd_word = '0;
      if (sh_d[6:0] == REG_CTRL)
         rd_word = sctrl_q;
      else if (sh_d[6:2] == REG_STAT[6:2])
         rd_word = snap_q[sh_d[1:0]];
   end

   always_comb
   begin
      sh_d = {sh_q[30:0], SPI.mosi};
      bcnt_d = bcnt_q + 5'd1;
      rd_d = rd_q;
      rsh_d = {rsh_q[14:0], 1'b0};
      wtgl_d = wtgl_q;
      wreg_d = wreg_q;
      wdat_d = wdat_q;
      // register byte complete: load the answer for the data bytes
      if (bcnt_q == 5'd15 && sh_d[15:8] == DEV_ADDR && sh_d[RD_BIT])
      begin
         rd_d = 1'b1;
         rsh_d = rd_word;
      end
      if (bcnt_q == 5'd31 && sh_d[31:24] == DEV_ADDR && !sh_d[23])
      begin
         wtgl_d = ~wtgl_q;
         wreg_d = sh_d[22:16];
         wdat_d = sh_d[15:0];
      end
   end

   always_ff @(posedge SPI.sck or posedge link_rst)
   begin
      if (link_rst)
      begin
         sh_q <= '0;
         bcnt_q <= '0;
         rd_q <= 1'b0;
         rsh_q <= '0;
      end
      else
      begin
         sh_q <= sh_d;
         bcnt_q <= bcnt_d;
         rd_q <= rd_d;
         rsh_q <= rsh_d;
      end
   end

   // write word and its toggle survive between frames
   always_ff @(posedge SPI.sck or negedge NRST)
   begin
      if (!NRST)
      begin
         wtgl_q <= 1'b0;
         wreg_q <= '0;
         wdat_q <= '0;
      end
      else
      begin
         wtgl_q <= wtgl_d;
         wreg_q <= wreg_d;
         wdat_q <= wdat_d;
      end
   end

   // read data changes on the falling edge, captured by the master at the next fall
   always_ff @(negedge SPI.sck or posedge link_rst)
   begin
      if (link_rst)
      begin
         miso_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else
      begin
         miso_q <= rsh_q[15];
         oe_q <= rd_q;
      end
   end

   assign SPI.miso = miso_q;
   assign SPI.miso_oe = oe_q;

   assign pin_raw = {SPI.cs_n, wtgl_q, OVER_TEMP, VMAIN_HIGH, CLS_CODE,
                     UNDER_MIN, OVER_CUT, AT_LIM, CAP_OK, SIG_OK};
   assign wevt = pin_q[34] ^ wseen_q;

   always_comb
   begin
      // a bit moves only when the second and third stages agree
      pin_d = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
      ctrl_d = ctrl_q;
      if (wevt && wreg_q == REG_CTRL)
         ctrl_d = wdat_q;
      sctrl_d = sctrl_q;
      snap_d = snap_q;
      // snapshot frozen while a frame is in flight
      if (pin_q[35])
      begin
         sctrl_d = ctrl_q;
         snap_d = stat;
      end
   end

   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         pin_q <= '0;
         wseen_q <= 1'b0;
         ctrl_q <= CTRL_RST;
         sctrl_q <= CTRL_RST;
         snap_q <= '{default: '0};
      end
      else
      begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d;
         wseen_q <= pin_q[34];
         ctrl_q <= ctrl_d;
         sctrl_q <= sctrl_d;
         snap_q <= snap_d;
      end
   end

   // sequencers run on the system oscillator
   for (genvar p = 0; p < NPORT; p++)
   begin : g_port
      pps_port_fsm #(
         .START_C(START_C),
         .DISC_C(DISC_C),
         .RECOV_C(RECOV_C),
         .OVL_C(OVL_C),
         .SHORT_C(SHORT_C)
      ) u_fsm (
         .clk(CLK_SYS),
         .nrst(NRST),
         .en(ctrl_q[CTRL_EN_LSB + p]),
         .type2(ctrl_q[CTRL_T2_LSB + p]),
         .legacy(ctrl_q[CTRL_LEG_LSB + p]),
         .sig_ok(pin_q[p]),
         .cap_ok(pin_q[4 + p]),
         .at_lim(pin_q[8 + p]),
         .over_cut(pin_q[12 + p]),
         .under_min(pin_q[16 + p]),
         .cls_code(pin_q[20 + 3 * p +: 3]),
         .ovt(pin_q[33]),
         .vhi(pin_q[32]),
         .det_on(DET_ON[p]),
         .det_lvl(DET_LEVEL[2 * p +: 2]),
         .cls_on(CLASS_ON[p]),
         .pwr_on(PORT_PWR[p]),
         .inrush(INRUSH_LIM[p]),
         .status(stat[p])
      );
   end
endmodule

// >>> hw/pps_host.sv
// host end: serial master issuing one four-byte frame per request
module pps_host
(
   input wire logic CLK_SYS,
   input wire logic NRST,
   pps_spi_if.host SPI,
   input wire logic REQ,
   input wire logic REQ_READ,
   input wire logic [7:0] REQ_DEV,
   input wire logic [6:0] REQ_REG,
   input wire logic [15:0] REQ_DATA,
   output logic READY,
   output logic DONE,
   output logic [15:0] RDATA
);
   import pps_pkg::*;
   pps_host_st_t st_q, st_d;
   logic [7:0] tmr_q, tmr_d;
   logic [4:0] bcnt_q, bcnt_d;
   logic [31:0] fr_q, fr_d;
   logic [15:0] rx_q, rx_d, rdat_d;
   logic sck_q, sck_d, cs_q, cs_d, rdy_d, done_d;
   logic m1_q, m2_q, m3_q, mf_q, mf_d;

   always_comb
   begin
      st_d = st_q;
      tmr_d = tmr_q + 8'd1;
      bcnt_d = bcnt_q;
      fr_d = fr_q;
      rx_d = rx_q;
      sck_d = sck_q;
      cs_d = cs_q;
      rdy_d = READY;
      done_d = 1'b0;
      rdat_d = RDATA;
      mf_d = (m2_q & m3_q) | (mf_q & (m2_q | m3_q));
      case (st_q)
         H_IDLE:
         begin
            tmr_d = '0;
            if (REQ)
            begin
               fr_d = {REQ_DEV, REQ_READ, REQ_REG, REQ_DATA};
               cs_d = 1'b0;
               rdy_d = 1'b0;
               bcnt_d = '0;
               st_d = H_SETUP;
            end
         end
         H_SETUP:
            if (tmr_q == 8'(CS_SETUP_CYC - 1))
            begin
               tmr_d = '0;
               st_d = H_BIT;
            end
         H_BIT:
         begin
            if (tmr_q == 8'(SCK_HALF_CYC - 1))
               sck_d = 1'b1;
            if (tmr_q == 8'(2 * SCK_HALF_CYC - 1))
            begin
               sck_d = 1'b0;
               tmr_d = '0;
               rx_d = {rx_q[14:0], mf_q};
               fr_d = {fr_q[30:0], 1'b0};
               bcnt_d = bcnt_q + 5'd1;
               if (bcnt_q == 5'd31)
                  st_d = H_HOLD;
               else if (bcnt_q[2:0] == 3'd7)
                  st_d = H_GAP;
            end
         end
         H_GAP:
            if (tmr_q == 8'(BYTE_GAP_SCK * 2 * SCK_HALF_CYC - 1))
            begin
               tmr_d = '0;
               st_d = H_BIT;
            end
         H_HOLD:
            if (tmr_q == 8'(CS_HOLD_CYC - 1))
            begin
               tmr_d = '0;
               cs_d = 1'b1;
               rdat_d = rx_q;
               done_d = 1'b1;
               st_d = H_CSHI;
            end
         H_CSHI:
            if (tmr_q == 8'(FRAME_GAP_SCK * 2 * SCK_HALF_CYC - 1))
            begin
               rdy_d = 1'b1;
               st_d = H_IDLE;
            end
         default:
            st_d = H_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         st_q <= H_IDLE;
         tmr_q <= '0;
         bcnt_q <= '0;
         fr_q <= '0;
         rx_q <= '0;
         sck_q <= 1'b0;
         cs_q <= 1'b1;
         READY <= 1'b1;
         DONE <= 1'b0;
         RDATA <= '0;
         m1_q <= 1'b0;
         m2_q <= 1'b0;
         m3_q <= 1'b0;
         mf_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         bcnt_q <= bcnt_d;
         fr_q <= fr_d;
         rx_q <= rx_d;
         sck_q <= sck_d;
         cs_q <= cs_d;
         READY <= rdy_d;
         DONE <= done_d;
         RDATA <= rdat_d;
         m1_q <= SPI.miso;
         m2_q <= m1_q;
         m3_q <= m2_q;
         mf_q <= mf_d;
      end
   end

   assign SPI.sck = sck_q;
   assign SPI.cs_n = cs_q;
   assign SPI.mosi = fr_q[31];
endmodule

// >>> dv/pps_props.sv
// link checker: framing and timing of the serial link between host and sequencer
module pps_props
import pps_pkg::*;
#(
   parameter logic [7:0] DEV_ADDR = DEV_ADDR_RST
)
(
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [9:0] lo_q, lo_d, hi_q, hi_d, cyc_q, cyc_d;
   logic [5:0] rise_q, rise_d;
   logic [15:0] sh_q, sh_d;
   logic sck_q;

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);

   // saturating counts of sck low, cs_n high and cycles selected, plus a wrapping count of rises per frame
   always_comb
   begin
      lo_d = sck ? 10'h000 : ((lo_q == 10'h3ff) ? lo_q : lo_q + 10'h001);
      hi_d = !cs_n ? 10'h000 : ((hi_q == 10'h3ff) ? hi_q : hi_q + 10'h001);
      cyc_d = cs_n ? 10'h000 : ((cyc_q == 10'h3ff) ? cyc_q : cyc_q + 10'h001);
      rise_d = cs_n ? 6'h00 : ((sck && !sck_q) ? rise_q + 6'h01 : rise_q);
      sh_d = (sck && !sck_q) ? {sh_q[14:0], mosi} : sh_q;
   end

   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         lo_q <= 10'h3ff;
         hi_q <= 10'h3ff;
         cyc_q <= 10'h000;
         rise_q <= 6'h00;
         sh_q <= 16'h0000;
         sck_q <= 1'b0;
      end
      else
      begin
         lo_q <= lo_d;
         hi_q <= hi_d;
         cyc_q <= cyc_d;
         rise_q <= rise_d;
         sh_q <= sh_d;
         sck_q <= sck;
      end
   end

   property p_idle; cs_n |-> !sck; endproperty
   a_idle: assert property (p_idle) else $error("sck active while deselected");
   property p_len; $rose(cs_n) |-> rise_q == 6'd32; endproperty
   a_len: assert property (p_len) else $error("frame not 32 clocks");
   property p_bgap; $rose(sck) && rise_q inside {6'd8, 6'd16, 6'd24} |-> lo_q >= 10'd16; endproperty
   a_bgap: assert property (p_bgap) else $error("byte pause too short");
   property p_fgap; $rose(sck) && rise_q == 6'd0 |-> lo_q >= 10'd32; endproperty
   a_fgap: assert property (p_fgap) else $error("frame pause too short");
   property p_csw; $fell(cs_n) |-> hi_q >= 10'd16; endproperty
   a_csw: assert property (p_csw) else $error("select high too short");
   property p_setup; $rose(sck) && rise_q == 6'd0 |-> cyc_q >= CS_SETUP_CYC; endproperty
   a_setup: assert property (p_setup) else $error("select setup too short");
   property p_hold; $rose(cs_n) |-> lo_q + SCK_HALF_CYC >= CS_HOLD_CYC; endproperty
   a_hold: assert property (p_hold) else $error("select hold too short");
   property p_oeoff; cs_n |-> !miso_oe; endproperty
   a_oeoff: assert property (p_oeoff) else $error("miso driven while deselected");
   property p_oehold; miso_oe && !cs_n |=> miso_oe || cs_n; endproperty
   a_oehold: assert property (p_oehold) else $error("miso released inside frame");
   property p_oeon; $rose(miso_oe) |-> rise_q == 6'd16 && sh_q[15:8] == DEV_ADDR && sh_q[7]; endproperty
   a_oeon: assert property (p_oeon) else $error("miso driven outside own read");
   property p_oewin; $rose(miso_oe) |-> cyc_q >= CS_SETUP_CYC + 248 && cyc_q <= CS_SETUP_CYC + 380;
   endproperty
   a_oewin: assert property (p_oewin) else $error("read data outside window");
endmodule

// >>> dv/poe_port_sequencer_spi_bench.sv
// self-checking bench joining the host end and the port sequencer
module poe_port_sequencer_spi_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import pps_pkg::*;
   localparam int ST_C = 200;
   localparam int DI_C = 100;
   localparam int RC_C = 300;
   localparam int OV_C = 50;
   localparam int SH_C = 40;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic req, req_read, ready, done, over_temp, vmain_high, watch_oe;
   logic oe_seen = 1'b0;
   logic [7:0] req_dev, det_level;
   logic [6:0] req_reg;
   logic [15:0] req_data, rdata, q;
   logic [3:0] sig_ok, cap_ok, at_lim, over_cut, under_min, det_on, class_on, port_pwr, inrush;
   logic [3:0] cls_prev = 4'h0;
   logic [3:0] lvl_seen = 4'h0;
   logic [11:0] cls_code;
   int cls_cnt [4];
   int inr_cnt, failures, num_checks, n;

   pps_spi_if pps_spi_if_i();
   pps_device #(.START_C(ST_C), .DISC_C(DI_C), .RECOV_C(RC_C), .OVL_C(OV_C), .SHORT_C(SH_C))
   pps_device_i (.CLK_SYS(clk_sys), .NRST(nrst), .SPI(pps_spi_if_i.dev), .SIG_OK(sig_ok),
      .CAP_OK(cap_ok), .AT_LIM(at_lim), .OVER_CUT(over_cut), .UNDER_MIN(under_min),
      .CLS_CODE(cls_code), .OVER_TEMP(over_temp), .VMAIN_HIGH(vmain_high), .DET_ON(det_on),
      .DET_LEVEL(det_level), .CLASS_ON(class_on), .PORT_PWR(port_pwr), .INRUSH_LIM(inrush));
   pps_host pps_host_i (.CLK_SYS(clk_sys), .NRST(nrst), .SPI(pps_spi_if_i.host), .REQ(req),
      .REQ_READ(req_read), .REQ_DEV(req_dev), .REQ_REG(req_reg), .REQ_DATA(req_data),
      .READY(ready), .DONE(done), .RDATA(rdata));
   pps_props #(.DEV_ADDR(DEV_ADDR_RST)) pps_props_i (.CLK_SYS(clk_sys), .NRST(nrst),
      .sck(pps_spi_if_i.sck), .cs_n(pps_spi_if_i.cs_n), .mosi(pps_spi_if_i.mosi),
      .miso_oe(pps_spi_if_i.miso_oe));

   always #4 clk_sys = ~clk_sys;

   // class events per port, detect levels and start-up length of port 0
   always @(posedge clk_sys)
   begin
      for (int p = 0; p < NPORT; p++)
         if (class_on[p] && !cls_prev[p])
            cls_cnt[p]++;
      cls_prev = class_on;
      if (det_on[0])
         lvl_seen[det_level[1:0]] = 1'b1;
      if (inrush[0])
         inr_cnt++;
      if (watch_oe && pps_spi_if_i.miso_oe)
         oe_seen = 1'b1;
   end

   task automatic close_out;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t value %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask

   // one frame through the host end; waits for completion and idle
   task automatic xfer(input logic rd, input logic [7:0] dev, input logic [6:0] rg,
      input logic [15:0] wd, output logic [15:0] rq);
      {req_read, req_dev, req_reg, req_data} = {rd, dev, rg, wd};
      req = 1'b1;
      tick(1);
      req = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 2000)
      begin
         tick(1);
         n++;
      end
      rq = rdata;
      while (ready !== 1'b1 && n < 2000)
      begin
         tick(1);
         n++;
      end
      if (n >= 2000)
         failures++;
   endtask

   task automatic wait_on(input logic det, input logic [3:0] m, input logic [3:0] v, input int lim);
      n = 0;
      while (((det ? det_on : port_pwr) & m) !== v && n < lim)
      begin
         tick(1);
         n++;
      end
      if (n >= lim)
         failures++;
   endtask

   task automatic stat(input int p, input logic [2:0] flt);
      xfer(1'b1, DEV_ADDR_RST, REG_STAT + 7'(p), 16'h0000, q);
      chk(16'(q[6:4]), 16'(flt));
   endtask

   task automatic t_config;
      xfer(1'b0, DEV_ADDR_RST, REG_CTRL, 16'h042f, q);
      xfer(1'b1, DEV_ADDR_RST, REG_CTRL, 16'h0000, q);
      chk(q, 16'h042f);
      watch_oe = 1'b1;
      xfer(1'b0, 8'h21, REG_CTRL, 16'h0000, q);
      xfer(1'b1, 8'h21, REG_CTRL, 16'h0000, q);
      watch_oe = 1'b0;
      chk(16'(oe_seen), 16'h0000);
      xfer(1'b1, DEV_ADDR_RST, REG_CTRL, 16'h0000, q);
      chk(q, 16'h042f);
   endtask

   task automatic t_bringup;
      wait_on(1'b0, 4'hf, 4'h7, 30000);
      chk(16'(port_pwr), 16'h0007);
      tick(ST_C + 20);
      chk(16'(inr_cnt >= ST_C && inr_cnt <= ST_C + 2), 16'h0001);
      chk(16'(lvl_seen), 16'h000f);
      chk(16'(cls_cnt[0]), 16'h0001);
      chk(16'(cls_cnt[1]), 16'h0002);
      chk(16'(cls_cnt[2]), 16'h0001);
      chk(16'(cls_cnt[3]), 16'h0000);
      xfer(1'b1, DEV_ADDR_RST, REG_STAT + 7'h01, 16'h0000, q);
      chk(16'(q[3:0]), 16'h0009);
   endtask

   task automatic t_faults;
      at_lim[0] = 1'b1;
      wait_on(1'b0, 4'h1, 4'h0, SH_C + 20);
      chk(16'(n >= SH_C), 16'h0001);
      at_lim[0] = 1'b0;
      stat(0, FLT_SHORT);
      over_cut[1] = 1'b1;
      wait_on(1'b0, 4'h2, 4'h0, OV_C + 20);
      chk(16'(n >= OV_C), 16'h0001);
      over_cut[1] = 1'b0;
      wait_on(1'b1, 4'h2, 4'h2, RC_C + 40);
      chk(16'(n >= RC_C), 16'h0001);
      stat(1, FLT_OVL);
      under_min[2] = 1'b1;
      wait_on(1'b0, 4'h4, 4'h0, DI_C + 20);
      chk(16'(n >= DI_C), 16'h0001);
      under_min[2] = 1'b0;
      stat(2, FLT_NOLOAD);
   endtask

   task automatic t_global;
      wait_on(1'b0, 4'h1, 4'h1, 30000);
      over_temp = 1'b1;
      wait_on(1'b0, 4'hf, 4'h0, 20);
      chk(16'(n < 20), 16'h0001);
      stat(0, FLT_TEMP);
      chk(16'(q[13:8]), 16'(S_IDLE));
      over_temp = 1'b0;
      wait_on(1'b0, 4'h1, 4'h1, 30000);
      vmain_high = 1'b1;
      wait_on(1'b0, 4'hf, 4'h0, 20);
      chk(16'(n < 20), 16'h0001);
      stat(0, FLT_VMAIN);
      vmain_high = 1'b0;
   endtask

   initial
   begin
      {req, req_read, req_dev, req_reg, req_data} = '0;
      {at_lim, over_cut, under_min, over_temp, vmain_high, watch_oe} = '0;
      {sig_ok, cap_ok, cls_code} = {4'b0011, 4'b1100, 3'd3, 3'd2, 3'd4, 3'd1};
      tick(20);
      nrst = 1'b1;
      chk({det_on, class_on, port_pwr, inrush}, 16'h0000);
      chk({15'h0000, ready}, 16'h0001);
      t_config;
      t_bringup;
      t_faults;
      t_global;
      close_out;
   end

   initial
   begin
      repeat (100000) @(posedge clk_sys);
      failures++;
      close_out;
   end
endmodule
